// File: hw/sism_defs.vh
`ifndef SISM_DEFS_VH
`define SISM_DEFS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
// Printed offsets are not all multiples of four: they are indices
`define SISM_IDX_RAW 8'hF9
`define SISM_IDX_STATUS 8'hFB
`define SISM_IDX_MASK 8'hFD
`define SISM_IDX_CLEAR 8'hFF
`define SISM_ADDR_RAW 12'h3E4
`define SISM_ADDR_STATUS 12'h3EC
`define SISM_ADDR_MASK 12'h3F4
`define SISM_ADDR_CLEAR 12'h3FC

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SISM_BIT_TUNER_DONE 0
`define SISM_BIT_TUNER_ERROR 1
`define SISM_BIT_ANT_RX_TIMEOUT 3
`define SISM_BIT_ANT_TX_DONE 4
`define SISM_BIT_ANT_RX_DONE 5
`define SISM_IMPL_BITS 8'h3B
`define SISM_RESET_BYTE 8'h00

`endif

// File: hw/sism_event_flags.v
`timescale 1ns/1ns
// ----------------------------------------
// Sticky raw event flags
// ----------------------------------------
module sism_event_flags #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Set pulses and clear strobes
  input wire [WIDTH-1:0] set_pulse,
  input wire [WIDTH-1:0] clear_strobe,
  // Flags
  output reg [WIDTH-1:0] flags
);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= {WIDTH{1'b0}};
    end else begin
      // Set wins over a clear in the same cycle
      flags <= (flags & ~clear_strobe) | set_pulse;
    end
  end

endmodule

// File: hw/sism_irq_ctrl.v
// Local design decision: register access over APB.
`timescale 1ns/1ns
`include "sism_defs.vh"

module sism_irq_ctrl #(
  parameter HW_IRQS = 1
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Event pulses from the link engines, same clock
  input wire antenna_rx_done,
  input wire antenna_tx_done,
  input wire antenna_rx_timeout,
  input wire tuner_xfer_error,
  input wire tuner_xfer_done,
  // Already-masked hardware interrupt sources
  input wire [HW_IRQS-1:0] hw_irq_status,
  // Host interrupt
  output reg host_irq_out
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg [7:0] irq_mask;
  reg [7:0] clear_strobe;
  wire [7:0] raw_flags;
  wire [7:0] set_pulse;
  wire [7:0] masked_status;
  wire access;
  wire wr;
  reg [7:0] next_rdata;
  reg next_err;

  // Bus handshake state
  reg [1:0] apb_state;
  reg [1:0] next_apb_state;
  // Register selects
  wire sel_raw;
  wire sel_status;
  wire sel_mask;
  wire sel_clear;
  wire sel_none;
  // Write and read enables
  wire wr_mask;
  wire wr_clear;
  wire rd;
  // Interrupt sources
  wire sw_irq_any;
  wire hw_irq_any;
  wire next_irq;
  reg [31:0] next_prdata;
  reg next_pslverr;
  reg next_pready;

  // ----------------------------------------
  // Handshake states
  // ----------------------------------------
  // Waiting for an access phase, or answering one
  localparam [1:0] APB_WAIT = 2'b01;
  localparam [1:0] APB_ANSWER = 2'b10;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Reserved positions are dropped everywhere a byte enters or leaves
  function [7:0] impl_bits;
    input [7:0] value;
    begin
      impl_bits = value & `SISM_IMPL_BITS;
    end
  endfunction

  // Full-address match only; aliases would hide software bugs
  function addr_hit;
    input [11:0] addr;
    input [11:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // Widen a register byte onto the data bus
  function [31:0] to_bus;
    input [7:0] value;
    begin
      to_bus = {24'h000000, value};
    end
  endfunction

  // Each register lives in the low byte of its word
  function [7:0] bus_byte;
    input [31:0] word;
    begin
      bus_byte = word[7:0];
    end
  endfunction

  // ----------------------------------------
  // Event mapping
  // ----------------------------------------
  // Reserved positions never receive an event
  assign set_pulse[`SISM_BIT_ANT_RX_DONE] = antenna_rx_done;
  assign set_pulse[`SISM_BIT_ANT_TX_DONE] = antenna_tx_done;
  assign set_pulse[`SISM_BIT_ANT_RX_TIMEOUT] = antenna_rx_timeout;
  assign set_pulse[`SISM_BIT_TUNER_ERROR] = tuner_xfer_error;
  // Done is dropped if the engine flags an error alongside it
  assign set_pulse[`SISM_BIT_TUNER_DONE] = tuner_xfer_done & ~tuner_xfer_error;
  assign set_pulse[2] = 1'b0;
  assign set_pulse[6] = 1'b0;
  assign set_pulse[7] = 1'b0;

  // ----------------------------------------
  // Raw flags
  // ----------------------------------------
  // Set and clear priority lives in the flag module
  sism_event_flags #(
    .WIDTH(8)
  ) u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set_pulse(set_pulse),
    .clear_strobe(clear_strobe),
    .flags(raw_flags)
  );

  // ----------------------------------------
  // Status
  // ----------------------------------------
  // Combinational AND: a cleared raw flag drops its status bit at once
  // Masked events remain visible in the raw register only
  assign masked_status = raw_flags & irq_mask & `SISM_IMPL_BITS;

  // ----------------------------------------
  // APB access
  // ----------------------------------------
  // Decoded once, shared by the read mux and the write port
  assign sel_raw = addr_hit(paddr, `SISM_ADDR_RAW);
  assign sel_status = addr_hit(paddr, `SISM_ADDR_STATUS);
  assign sel_mask = addr_hit(paddr, `SISM_ADDR_MASK);
  assign sel_clear = addr_hit(paddr, `SISM_ADDR_CLEAR);
  assign sel_none = ~(sel_raw | sel_status | sel_mask | sel_clear);

  // Taken only while waiting, so each transfer is seen once
  assign access = psel & penable & apb_state[0];
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign wr_mask = wr & sel_mask;
  assign wr_clear = wr & sel_clear;

  // ----------------------------------------
  // Handshake
  // ----------------------------------------
  always @* begin
    next_apb_state = apb_state;
    case (apb_state)
      APB_WAIT: begin
        if (access) begin
          next_apb_state = APB_ANSWER;
        end
      end
      APB_ANSWER: begin
        next_apb_state = APB_WAIT;
      end
      default: begin
        next_apb_state = APB_WAIT;
      end
    endcase
  end

  // ----------------------------------------
  // Answer
  // ----------------------------------------
  // Answer values prepared here so the outputs stay plain flops
  always @* begin
    next_pready = 1'b0;
    next_prdata = 32'h00000000;
    next_pslverr = 1'b0;
    if (access) begin
      next_pready = 1'b1;
      next_pslverr = next_err;
      if (rd) begin
        next_prdata = to_bus(next_rdata);
      end
    end
  end

  // Single wait state: answer one cycle after access phase starts
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state <= APB_WAIT;
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      apb_state <= next_apb_state;
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  // Read mux; the clear register is write-only and reads back zero
  always @* begin
    next_rdata = 8'h00;
    next_err = 1'b0;
    if (sel_raw) begin
      next_rdata = impl_bits(raw_flags);
    end
    if (sel_status) begin
      next_rdata = masked_status;
    end
    if (sel_mask) begin
      next_rdata = impl_bits(irq_mask);
    end
    if (sel_clear) begin
      next_rdata = 8'h00;
    end
    if (sel_none) begin
      next_err = 1'b1;
    end
  end

  // ----------------------------------------
  // Mask register
  // ----------------------------------------
  // Written at the taken edge, the same edge that raises pready
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= `SISM_RESET_BYTE;
    end else begin
      if (wr_mask) begin
        irq_mask <= impl_bits(bus_byte(pwdata));
      end
    end
  end

  // ----------------------------------------
  // Clear strobe
  // ----------------------------------------
  // One-cycle strobe, then back to zero
  // Software never sees it: a read of the clear address gives zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_strobe <= `SISM_RESET_BYTE;
    end else begin
      if (wr_clear) begin
        clear_strobe <= impl_bits(bus_byte(pwdata));
      end else begin
        clear_strobe <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Interrupt output
  // ----------------------------------------
  // Software part only counts enabled, implemented positions
  assign sw_irq_any = |masked_status;
  // Hardware sources arrive already masked by their own block
  assign hw_irq_any = |hw_irq_status;
  assign next_irq = sw_irq_any | hw_irq_any;

  // Registered, so it trails the status register by one cycle
  // A user polling status sees the bit in prdata in the same cycle as the pin, as prdata is registered too
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_irq_out <= 1'b0;
    end else begin
      host_irq_out <= next_irq;
    end
  end

endmodule

// File: tb/sism_host.sv
`timescale 1ns/1ns
// Host processor as APB master; a released bus shows inverted address and data
module sism_host (
  input logic pclk, pready, pslverr,
  input logic [31:0] prdata,
  output logic psel = 0, penable = 0, pwrite = 0,
  output logic [11:0] paddr = 0,
  output logic [31:0] pwdata = 0);
  task automatic xfer(bit w, logic [11:0] a, logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// File: tb/sism_irq_checker.sv
`timescale 1ns/1ns
module sism_irq_checker #(parameter HW_IRQS = 1) (
  input logic pclk, presetn, psel, penable, pwrite, pready, pslverr, host_irq_out,
  input logic [11:0] paddr,
  input logic [31:0] pwdata, prdata,
  input logic [HW_IRQS-1:0] hw_irq_status);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] msk;
  sequence s_take; psel && penable && !pready; endsequence
  sequence s_rd; pready && !pwrite; endsequence
  always @(posedge pclk or negedge presetn)
    if (!presetn) msk <= 8'h00;
    else if (psel && penable && !pready && pwrite && paddr == 12'h3F4) msk <= pwdata[7:0] & 8'h3B;
  a_one_wait: assert property (s_take |=> pready ##1 !pready) else $error("ready timing");
  a_rsvd_zero: assert property (s_rd |-> !(prdata & 32'hFFFFFFC4)) else $error("reserved bits");
  a_mask_back: assert property ((s_rd and paddr == 12'h3F4) |-> prdata == msk) else $error("mask read");
  a_clear_zero: assert property ((s_rd and paddr == 12'h3FC) |-> !prdata) else $error("clear read");
  a_hw_irq: assert property (|hw_irq_status |=> host_irq_out) else $error("hw irq");
  a_bad_addr: assert property (pready |-> pslverr == !(paddr inside {12'h3E4, 12'h3EC, 12'h3F4, 12'h3FC}))
    else $error("slverr");
  a_idle_quiet: assert property (!pready |-> !prdata && !pslverr) else $error("idle data");
  a_wr_quiet: assert property (pready && pwrite |-> !prdata) else $error("write data");
endmodule
bind sism_irq_ctrl sism_irq_checker #(.HW_IRQS(HW_IRQS)) u_chk (.*);

// File: tb/sism_irq_ctrl_tb.sv
`timescale 1ns/1ns
module sism_irq_ctrl_tb;
  typedef struct {logic [7:0] ev, msk, raw;} sism_row_t;
  sism_row_t rows[7] = '{'{8'h20, 8'h3B, 8'h20}, '{8'h10, 8'h10, 8'h10}, '{8'h08, 8'hFF, 8'h08},
    '{8'h02, 8'h02, 8'h02}, '{8'h01, 8'h01, 8'h01}, '{8'h03, 8'h01, 8'h02}, '{8'h3B, 8'h00, 8'h3A}};
  logic pclk = 0, presetn = 0, e;
  logic [7:0] ev = 0;
  logic [0:0] hw = 0;
  logic [31:0] q;
  wire psel, penable, pwrite, pready, pslverr, irq;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  int bad_count = 0, n_compared = 0;
  always #20 pclk = ~pclk;
  sism_host u_sism_host (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
  sism_irq_ctrl u_sism_irq_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .antenna_rx_done(ev[5]), .antenna_tx_done(ev[4]), .antenna_rx_timeout(ev[3]),
    .tuner_xfer_error(ev[1]), .tuner_xfer_done(ev[0]), .hw_irq_status(hw), .host_irq_out(irq));
  task chk(string nm, logic [31:0] s, x);
    n_compared++;
    if (s !== x) begin
      bad_count++;
      $display("ERROR %s exp %h seen %h", nm, x, s);
    end
  endtask
  task rc(string nm, logic [11:0] a, logic [31:0] x);
    u_sism_host.xfer(0, a, 0, q, e);
    chk(nm, q, x);
  endtask
  task wr(logic [11:0] a, logic [7:0] d);
    u_sism_host.xfer(1, a, d, q, e);
  endtask
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    finish_test;
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    foreach (rows[i]) begin
      wr(12'h3FC, 8'h3B);
      wr(12'h3F4, rows[i].msk);
      @(posedge pclk) ev <= rows[i].ev;
      @(posedge pclk) ev <= 0;
      rc("raw", 12'h3E4, rows[i].raw);
      rc("status", 12'h3EC, rows[i].raw & rows[i].msk);
      rc("mask", 12'h3F4, rows[i].msk & 8'h3B);
      chk("irq", irq, |(rows[i].raw & rows[i].msk));
      $display("row %0d done", i);
    end
    wr(12'h3F4, 8'h3B);
    rc("status", 12'h3EC, 8'h3A);
    wr(12'h3FC, 8'h20);
    rc("status", 12'h3EC, 8'h1A);
    rc("clear", 12'h3FC, 0);
    // Event pulse lands in the clear strobe cycle
    fork
      wr(12'h3FC, 8'h1B);
      begin
        repeat (3) @(posedge pclk);
        ev <= 8'h01;
        @(posedge pclk) ev <= 0;
      end
    join
    rc("set wins", 12'h3E4, 1);
    wr(12'h3FC, 8'h01);
    repeat (2) @(negedge pclk);
    chk("irq", irq, 0);
    @(posedge pclk) hw <= 1;
    repeat (2) @(negedge pclk);
    chk("hw irq", irq, 1);
    @(posedge pclk) hw <= 0;
    rc("unmapped", 12'h100, 0);
    chk("slverr", e, 1);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rc("mask", 12'h3F4, 0);
    rc("status", 12'h3EC, 0);
    $display("hand tests done");
    finish_test;
  end
endmodule
